// ### design/uarc_serial_port.v
// Serial port control, status, receive path and AHB-Lite register slave.
//
// Notes on behaviour
// - With nine-bit address detect on, only ninth-bit-one characters raise pending.
// - Nine-bit address detect loads only when bit 8 set; ignored in 8-bit.
// - Port enable clear holds the baud, receive, transmit and buffer logic in reset.
// - Nine-bit select chooses width; ninth received bit reads at bit 0.
// - Single receive runs one sync host reception, then hardware clears it.
// - Continuous receive enables receiver; in sync mode overrides single.
// - Overrun flag sets on overrun; clearing continuous receive clears it.
// - Framing flag follows the oldest unread character, updating on read.
// - Clock source select picks host or client in sync mode.
// - Transmit enable gates sending; sync receive enables override it.
// - Mode bit selects synchronous when one, asynchronous when zero.
// - Break request sends a break next transmission, cleared when done.
// - High baud select chooses the fast multiplier in async mode.
// - Transmit shift empty reads one when empty, resets to one.
// - Auto-baud overflow flags a timer overflow during detection.
// - Receive idle reads one when idle, zero from start bit detection.
// - Polarity inverts async transmit data; has no effect in sync mode.
// - Wide divider select makes the baud generator sixteen bits.
// - Wake-up waits for a falling edge, flags pending, then self-clears.
// - Auto-baud enable starts detection; hardware clears it when done.
// - Zero-ninth-bit characters are dropped while nine-bit address detect is on.
// - Buffer holds two; a third character overruns and stops reception.
// - Receive pending is set while enabled and an unread character exists.
`timescale 1ns/1ps
`include "uarc_consts.vh"
module uarc_serial_port (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Serial pins
    input wire rx_pin,
    output reg tx_pin,
    // Receive pending level for the system interrupt controller
    output reg receive_pending_flag
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_STOP = 4'b1000;
    reg [7:0] rxc_q, txc_q, bc_q, brg_lo_q, brg_hi_q;
    reg overrun_error_flag_q, autobaud_overflow_flag_q;
    reg rx_s1_q, rx_s2_q, rx_prev_q;
    reg [3:0] st_q;
    reg [3:0] ph_q;
    reg [3:0] bit_q;
    reg [8:0] sh_q;
    reg [8:0] fifo_d9_q [0:1];
    reg [1:0] fifo_fe_q;
    reg [1:0] cnt_q;
    reg [15:0] abd_cnt_q;
    reg [1:0] abd_st_q;
    reg [11:0] a_addr_q;
    reg a_wr_q, a_rd_q;
    reg [10:0] tsh_q;
    reg [3:0] tbits_q, tph_q;
    reg tbusy_q, tbrk_q;
    reg [8:0] tdat_q;
    reg tpend_q;
    wire tick;
    wire port_on;
    wire sync_mode;
    wire rx_en;
    wire rx_fall;
    wire rd_data;
    wire a_take;
    wire done;
    wire accept;
    wire [8:0] head;
    // Port enable low holds the other control registers and the baud, receive, transmit and buffer logic in reset.
    assign port_on = rxc_q[`UARC_RX_PORT_EN];
    wire rst_port = sys_rst | ~port_on;
    assign sync_mode = txc_q[`UARC_TX_SYNC];
    // Sync client ignores single receive; continuous wins over single.
    assign rx_en = rxc_q[`UARC_RX_CONT] | (sync_mode &
        txc_q[`UARC_TX_CLOCK_SOURCE_SELECT] & rxc_q[`UARC_RX_SINGLE]);
    assign rx_fall = rx_prev_q & ~rx_s2_q;
    assign a_take = hsel & htrans[1] & hready;
    assign rd_data = a_rd_q & (a_addr_q == `UARC_OFF_RECEIVE_DATA);
    assign done = (st_q == ST_STOP) & tick & (ph_q == 4'hf);
    // Nine-bit with address detect keeps only bit-8-set characters.
    assign accept = ~(rxc_q[`UARC_RX_NINE] & rxc_q[`UARC_RX_ADDR]) |
        sh_q[8];
    assign head = fifo_d9_q[0];
    uarc_baud_gen u_baud (
        .clk_sys(clk_sys),
        .rst(rst_port),
        .divisor({brg_hi_q, brg_lo_q}),
        .wide(bc_q[`UARC_BC_WIDE]),
        .high_speed(txc_q[`UARC_TX_HIGH]),
        .sync_mode(sync_mode),
        .tick(tick)
    );
    // Pin synchroniser; the second stage and a delayed copy of it for edge detection are examined.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
        end
    end
    // Bus address phase capture; the slave never inserts wait states.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            a_wr_q <= 1'b0;
            a_rd_q <= 1'b0;
            a_addr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            a_wr_q <= a_take & hwrite;
            a_rd_q <= a_take & ~hwrite;
            if (a_take) begin
                a_addr_q <= haddr;
            end
        end
    end
    // Register writes and hardware self-clears.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rxc_q <= 8'h00;
        end else if (a_wr_q && a_addr_q == `UARC_OFF_RX_STATUS_CONTROL) begin
            rxc_q <= hwdata[7:0] & `UARC_RX_CTRL_MASK;
        end else if (done && sync_mode && !rxc_q[`UARC_RX_CONT]) begin
            rxc_q[`UARC_RX_SINGLE] <= 1'b0;
        end
    end
    always @(posedge clk_sys) begin
        if (rst_port) begin
            txc_q <= 8'h00;
            bc_q <= 8'h00;
            brg_lo_q <= 8'h00;
            brg_hi_q <= 8'h00;
        end else begin
            if (a_wr_q && a_addr_q == `UARC_OFF_TX_STATUS_CONTROL) begin
                txc_q <= hwdata[7:0] & `UARC_TX_CTRL_MASK;
            end else if (tbusy_q && tbrk_q && tbits_q == 4'h0 &&
                    tph_q == 4'hf && tick) begin
                txc_q[`UARC_TX_BREAK] <= 1'b0;
            end
            if (a_wr_q && a_addr_q == `UARC_OFF_BAUD_CONTROL) begin
                bc_q <= hwdata[7:0] & `UARC_BC_CTRL_MASK;
            end else begin
                if (bc_q[`UARC_BC_WAKE] && !sync_mode && rx_fall) begin
                    bc_q[`UARC_BC_WAKE] <= 1'b0;
                end
                if (abd_st_q == 2'h3 || autobaud_overflow_flag_q) begin
                    bc_q[`UARC_BC_ABD] <= 1'b0;
                end
            end
            if (a_wr_q && a_addr_q == `UARC_OFF_BAUD_DIVISOR_LOW) begin
                brg_lo_q <= hwdata[7:0];
            end else if (abd_st_q == 2'h3) begin
                brg_lo_q <= abd_cnt_q[11:4];
            end
            if (a_wr_q && a_addr_q == `UARC_OFF_BAUD_DIVISOR_HIGH) begin
                brg_hi_q <= hwdata[7:0];
            end else if (abd_st_q == 2'h3) begin
                brg_hi_q <= {4'h0, abd_cnt_q[15:12]};
            end
        end
    end
    // Auto-baud: time from first falling edge to the second falling edge.
    // Counts system clocks; the result divided by sixteen sets the divisor.
    always @(posedge clk_sys) begin
        if (rst_port || !bc_q[`UARC_BC_ABD] || sync_mode) begin
            abd_st_q <= 2'h0;
            abd_cnt_q <= 16'h0000;
            if (rst_port) begin
                autobaud_overflow_flag_q <= 1'b0;
            end
        end else begin
            case (abd_st_q)
                2'h0: begin
                    if (rx_fall) begin
                        abd_st_q <= 2'h1;
                    end
                end
                2'h1: begin
                    abd_cnt_q <= abd_cnt_q + 16'h0001;
                    if (abd_cnt_q == 16'hffff) begin
                        autobaud_overflow_flag_q <= 1'b1;
                    end
                    if (rx_fall) begin
                        abd_st_q <= 2'h2;
                    end
                end
                2'h2: abd_st_q <= 2'h3;
                default: abd_st_q <= 2'h0;
            endcase
        end
    end
    // Receiver state machine, sixteen ticks per bit.
    always @(posedge clk_sys) begin
        if (rst_port || !rx_en || bc_q[`UARC_BC_WAKE] ||
                bc_q[`UARC_BC_ABD]) begin
            st_q <= ST_IDLE;
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 9'h000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (rx_fall && !overrun_error_flag_q) begin
                        st_q <= ST_START;
                        ph_q <= 4'h0;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        ph_q <= ph_q + 4'h1;
                        if (ph_q == 4'h7) begin
                            // A glitch aborts without error.
                            st_q <= rx_s2_q ? ST_IDLE : ST_DATA;
                            ph_q <= 4'h0;
                            bit_q <= 4'h0;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        ph_q <= ph_q + 4'h1;
                        if (ph_q == 4'hf) begin
                            sh_q <= rxc_q[`UARC_RX_NINE] ? {rx_s2_q,
                                sh_q[8:1]} : {1'b0, rx_s2_q, sh_q[7:1]};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == (rxc_q[`UARC_RX_NINE] ? 4'h8 : 4'h7)) begin
                                st_q <= ST_STOP;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        ph_q <= ph_q + 4'h1;
                        if (ph_q == 4'hf) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // Two-entry receive buffer with overrun; a same-cycle push and pop both take effect.
    always @(posedge clk_sys) begin
        if (rst_port) begin
            cnt_q <= 2'h0;
            fifo_fe_q <= 2'b00;
            fifo_d9_q[0] <= 9'h000;
            fifo_d9_q[1] <= 9'h000;
            overrun_error_flag_q <= 1'b0;
        end else begin
            if (!rxc_q[`UARC_RX_CONT]) begin
                overrun_error_flag_q <= 1'b0;
            end
            if (done && accept && cnt_q == 2'h2 && !rd_data) begin
                overrun_error_flag_q <= 1'b1;
            end else if (done && accept) begin
                if (rd_data && cnt_q != 2'h0) begin
                    fifo_d9_q[0] <= (cnt_q == 2'h2) ? fifo_d9_q[1] : sh_q;
                    fifo_fe_q[0] <= (cnt_q == 2'h2) ? fifo_fe_q[1] : ~rx_s2_q;
                    fifo_d9_q[1] <= sh_q;
                    fifo_fe_q[1] <= ~rx_s2_q;
                end else begin
                    fifo_d9_q[cnt_q[0]] <= sh_q;
                    fifo_fe_q[cnt_q[0]] <= ~rx_s2_q;
                    cnt_q <= cnt_q + 2'h1;
                end
            end else if (rd_data && cnt_q != 2'h0) begin
                fifo_d9_q[0] <= fifo_d9_q[1];
                fifo_fe_q[0] <= fifo_fe_q[1];
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
    // Transmitter: start, data, optional ninth bit, stop; break is eleven zero bits then stop.
    always @(posedge clk_sys) begin
        tx_pin <= tsh_q[0] ^ (bc_q[`UARC_BC_POL] & ~sync_mode);
        if (rst_port) begin
            tsh_q <= 11'h7ff;
            tbusy_q <= 1'b0;
            tbrk_q <= 1'b0;
            tbits_q <= 4'h0;
            tph_q <= 4'h0;
            tpend_q <= 1'b0;
            tdat_q <= 9'h000;
            tx_pin <= 1'b1;
        end else begin
            // Sync receive enables override transmit enable.
            if (!tbusy_q && tpend_q && txc_q[`UARC_TX_EN] &&
                    !(sync_mode && (rxc_q[`UARC_RX_CONT] ||
                    rxc_q[`UARC_RX_SINGLE]))) begin
                tpend_q <= 1'b0;
                tbusy_q <= 1'b1;
                tph_q <= 4'h0;
                tbrk_q <= txc_q[`UARC_TX_BREAK] & ~sync_mode;
                if (txc_q[`UARC_TX_BREAK] && !sync_mode) begin
                    tsh_q <= 11'h000;
                    tbits_q <= 4'hc;
                end else if (txc_q[`UARC_TX_NINE]) begin
                    tsh_q <= {1'b1, tdat_q, 1'b0};
                    tbits_q <= 4'ha;
                end else begin
                    tsh_q <= {2'b11, tdat_q[7:0], 1'b0};
                    tbits_q <= 4'h9;
                end
            end else if (tbusy_q && tick) begin
                tph_q <= tph_q + 4'h1;
                if (tph_q == 4'hf) begin
                    tsh_q <= {(tbits_q > 4'h2), tsh_q[10:1]};
                    tbits_q <= tbits_q - 4'h1;
                    if (tbits_q == 4'h0) begin
                        tbusy_q <= 1'b0;
                        tsh_q <= 11'h7ff;
                    end
                end
            end
            if (a_wr_q && a_addr_q == `UARC_OFF_TX_DATA) begin
                tpend_q <= 1'b1;
                tdat_q <= {txc_q[`UARC_TX_D9], hwdata[7:0]};
            end
        end
    end
    // Read data and pending flag.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
            receive_pending_flag <= 1'b0;
        end else begin
            receive_pending_flag <= port_on & rx_en & (cnt_q != 2'h0);
            if (bc_q[`UARC_BC_WAKE] && !sync_mode && rx_fall) begin
                receive_pending_flag <= 1'b1;
            end
            hrdata <= 32'h00000000;
            if (a_take && !hwrite) begin
                case (haddr)
                    `UARC_OFF_BAUD_CONTROL: hrdata[7:0] <= bc_q |
                        {autobaud_overflow_flag_q, (st_q == ST_IDLE), 6'h00};
                    `UARC_OFF_RECEIVE_DATA: hrdata[7:0] <= head[7:0];
                    `UARC_OFF_RX_STATUS_CONTROL: hrdata[7:0] <= rxc_q |
                        {5'h00, fifo_fe_q[0] & (cnt_q != 2'h0), overrun_error_flag_q,
                        head[8]};
                    `UARC_OFF_BAUD_DIVISOR_LOW: hrdata[7:0] <= brg_lo_q;
                    `UARC_OFF_BAUD_DIVISOR_HIGH: hrdata[7:0] <= brg_hi_q;
                    `UARC_OFF_TX_STATUS_CONTROL: hrdata[7:0] <= txc_q |
                        {6'h00, ~tbusy_q, 1'b0};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // uarc_serial_port

// ### design/uarc_consts.vh
// Register map, field positions, write masks and buffer depth for the serial port.
`ifndef UARC_CONSTS_VH
`define UARC_CONSTS_VH
`define UARC_OFF_BAUD_CONTROL 12'h000
`define UARC_OFF_RECEIVE_DATA 12'h004
`define UARC_OFF_RX_STATUS_CONTROL 12'h008
`define UARC_OFF_BAUD_DIVISOR_LOW 12'h00c
`define UARC_OFF_BAUD_DIVISOR_HIGH 12'h010
`define UARC_OFF_TX_STATUS_CONTROL 12'h014
`define UARC_OFF_TX_DATA 12'h018
`define UARC_RX_PORT_EN 7
`define UARC_RX_NINE 6
`define UARC_RX_SINGLE 5
`define UARC_RX_CONT 4
`define UARC_RX_ADDR 3
`define UARC_RX_FRAMING_ERROR_FLAG 2
`define UARC_RX_OVERRUN_ERROR_FLAG 1
`define UARC_RX_D9 0
`define UARC_TX_CLOCK_SOURCE_SELECT 7
`define UARC_TX_NINE 6
`define UARC_TX_EN 5
`define UARC_TX_SYNC 4
`define UARC_TX_BREAK 3
`define UARC_TX_HIGH 2
`define UARC_TX_EMPTY 1
`define UARC_TX_D9 0
`define UARC_BC_AUTOBAUD_OVERFLOW_FLAG 7
`define UARC_BC_IDLE 6
`define UARC_BC_POL 4
`define UARC_BC_WIDE 3
`define UARC_BC_WAKE 1
`define UARC_BC_ABD 0
`define UARC_RX_CTRL_MASK 8'hf8
`define UARC_TX_CTRL_MASK 8'hfd
`define UARC_BC_CTRL_MASK 8'h1b
`define UARC_FIFO_DEPTH 2
`endif

// ### design/uarc_baud_gen.v
// Baud tick generator: divider plus sixteen-phase sampling enable.
`timescale 1ns/1ps
module uarc_baud_gen (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Configuration
    input wire [15:0] divisor,
    input wire wide,
    input wire high_speed,
    input wire sync_mode,
    // Tick out
    output reg tick
);
    reg [15:0] cnt_q;
    reg [1:0] pre_q;
    wire [15:0] top;
    wire [1:0] pre_top;
    assign top = wide ? divisor : {8'h00, divisor[7:0]};
    // Low speed in async mode with the narrow divider adds a divide by four to the sample tick.
    assign pre_top = (sync_mode || high_speed || wide) ? 2'h0 : 2'h3;
    always @(posedge clk_sys) begin
        tick <= 1'b0;
        if (rst) begin
            cnt_q <= 16'h0000;
            pre_q <= 2'h0;
        end else if (cnt_q >= top) begin
            cnt_q <= 16'h0000;
            if (pre_q >= pre_top) begin
                pre_q <= 2'h0;
                tick <= 1'b1;
            end else begin
                pre_q <= pre_q + 2'h1;
            end
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule // uarc_baud_gen

// ### dv/uarc_serial_port_checker.sv
// Concurrent checks on the serial port's bus and pin behaviour.
`timescale 1ns/1ps
module uarc_serial_port_checker (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Bus
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Pins
    input wire rx_pin,
    input wire tx_pin,
    input wire receive_pending_flag
);
    logic rd_q, wr_q, en_q;
    logic [11:0] a_q;
    logic [3:0] pop_q, off_q;
    wire take = hsel && htrans[1] && hready;
    wire pop = rd_q && a_q == 12'h004;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            if (wr_q && a_q == 12'h008) begin
                en_q <= hwdata[7] && hwdata[4];
            end
        end
        if (take) begin
            a_q <= haddr;
        end
        pop_q <= {pop_q[2:0], pop};
        off_q <= {off_q[2:0], !en_q};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence port_off_s;
        wr_q && a_q == 12'h008 && !hwdata[7];
    endsequence
    sequence quiet_s;
        (!receive_pending_flag && tx_pin) [*3];
    endsequence
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    zero_wait_a: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    idle_rdata_a: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("hrdata not zero outside data phase");
    upper_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    unmapped_zero_a: assert property (rd_q && a_q > 12'h018 |-> hrdata == 0)
        else $error("unmapped read not zero");
    port_off_a: assert property (port_off_s |-> ##2 quiet_s)
        else $error("port disabled but not quiet");
    pend_fall_a: assert property ($fell(receive_pending_flag) |->
        (|pop_q) || (|off_q) || !$past(receive_pending_flag, 2))
        else $error("pending dropped without a read");
    pend_needs_en_a: assert property (&off_q |-> !receive_pending_flag)
        else $error("pending while receiver off");
endmodule // uarc_serial_port_checker

bind uarc_serial_port uarc_serial_port_checker u_uarc_serial_port_checker (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .receive_pending_flag(receive_pending_flag));

// ### dv/uarc_remote_node.sv
// Remote serial node that drives the receive line.
`timescale 1ns/1ps
module uarc_remote_node (
    // Clock
    input wire clk_sys,
    // Line
    output logic rx_line
);
    initial rx_line = 1'b1;
    // Each bit lasts 16 clocks, which matches a divisor of zero when wide.
    task automatic send(input logic [8:0] ch, input int nb, input logic stp);
        for (int i = 0; i < nb + 2; i++) begin
            rx_line <= (i == 0) ? 1'b0 : (i > nb) ? stp : ch[i-1];
            repeat (16) @(posedge clk_sys);
        end
        rx_line <= 1'b1;
    endtask
endmodule // uarc_remote_node

// ### dv/tb_uart_async_rx_control.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
module tb_uart_async_rx_control;
    logic clk_sys, sys_rst, hsel, hwrite, pend_d;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, rx_pin;
    logic tx_pin, receive_pending_flag;
    int fails, cmp_count, rises, n0;

    uarc_serial_port u_uarc_serial_port (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .receive_pending_flag(receive_pending_flag));
    uarc_remote_node u_uarc_remote_node (.clk_sys(clk_sys), .rx_line(rx_pin));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        pend_d <= receive_pending_flag;
        if (receive_pending_flag === 1'b1 && pend_d === 1'b0) begin
            rises <= rises + 1;
        end
    end

    task automatic bus(input logic [11:0] a, input logic w,
            input logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge clk_sys);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do begin
            @(posedge clk_sys);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a,
            input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        chk(nm, e, rd);
    endtask
    // The pending level follows a pop two edges later, so let it settle.
    task automatic pinchk(input string nm, input logic e, ref logic g);
        repeat (2) @(posedge clk_sys);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic frame(input logic [8:0] ch, input int nb, input logic stp);
        u_uarc_remote_node.send(ch, nb, stp);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // About 2200 cycles are expected; the limit leaves wide margin.
    initial begin
        #200000;
        fails++;
        finish_test;
    end

    initial begin
        sys_rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {fails, cmp_count, rises, pend_d} = '0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk("rx_ctl", 12'h008, 32'h00);
        rdchk("tx_ctl", 12'h014, 32'h02);
        rdchk("baud_ctl", 12'h000, 32'h40);
        bus(12'h01c, 1'b1, 8'hff);
        rdchk("unmapped", 12'h01c, 32'h00);
        $display("test reset done");
        bus(12'h008, 1'b1, 8'h90);
        bus(12'h000, 1'b1, 8'hc8);
        bus(12'h00c, 1'b1, 8'h00);
        bus(12'h010, 1'b1, 8'h00);
        rdchk("baud_ro", 12'h000, 32'h48);
        fork
            frame(9'h0a5, 8, 1'b1);
            begin
                repeat (60) @(posedge clk_sys);
                rdchk("busy", 12'h000, 32'h08);
            end
        join
        pinchk("pending", 1'b1, receive_pending_flag);
        rdchk("rx_st8", 12'h008, 32'h90);
        rdchk("data8", 12'h004, 32'ha5);
        pinchk("drained", 1'b0, receive_pending_flag);
        $display("test receive done");
        bus(12'h008, 1'b1, 8'hd8);
        frame(9'h012, 9, 1'b1);
        pinchk("addr_drop", 1'b0, receive_pending_flag);
        frame(9'h1a7, 9, 1'b1);
        pinchk("addr_take", 1'b1, receive_pending_flag);
        rdchk("rx_st9", 12'h008, 32'hd9);
        rdchk("addr", 12'h004, 32'ha7);
        bus(12'h008, 1'b1, 8'hd0);
        frame(9'h033, 9, 1'b1);
        rdchk("rx_st9b", 12'h008, 32'hd0);
        rdchk("data9", 12'h004, 32'h33);
        $display("test address done");
        bus(12'h008, 1'b1, 8'h98);
        frame(9'h05a, 8, 1'b0);
        frame(9'h03c, 8, 1'b1);
        rdchk("framing_error_flag", 12'h008, 32'h9c);
        rdchk("data_a", 12'h004, 32'h5a);
        rdchk("framing_error_flag_next", 12'h008, 32'h98);
        rdchk("data_b", 12'h004, 32'h3c);
        for (int i = 1; i < 4; i++) begin
            frame(9'(i * 17), 8, 1'b1);
        end
        rdchk("overrun", 12'h008, 32'h9a);
        rdchk("keep_a", 12'h004, 32'h11);
        rdchk("keep_b", 12'h004, 32'h22);
        bus(12'h008, 1'b1, 8'h88);
        rdchk("overrun_error_flag_clr", 12'h008, 32'h88);
        $display("test errors done");
        bus(12'h008, 1'b1, 8'h90);
        n0 = rises;
        bus(12'h000, 1'b1, 8'h0a);
        frame(9'h0ff, 8, 1'b1);
        chk("wake_pulse", 32'h1, 32'(rises - n0));
        rdchk("wake_clr", 12'h000, 32'h48);
        pinchk("wake_empty", 1'b0, receive_pending_flag);
        bus(12'h014, 1'b1, 8'h20);
        bus(12'h018, 1'b1, 8'h00);
        rdchk("tx_busy", 12'h014, 32'h20);
        pinchk("tx_start", 1'b0, tx_pin);
        repeat (200) @(posedge clk_sys);
        rdchk("tx_idle", 12'h014, 32'h22);
        bus(12'h000, 1'b1, 8'h18);
        rdchk("pol", 12'h000, 32'h58);
        pinchk("tx_inv", 1'b0, tx_pin);
        $display("test wake and transmit done");
        bus(12'h000, 1'b1, 8'h09);
        frame(9'h055, 8, 1'b1);
        bus(12'h000, 1'b0, 8'h00);
        chk("abd_clr", 32'h08, rd & 32'hbf);
        bus(12'h008, 1'b1, 8'h00);
        rdchk("port_off", 12'h000, 32'h40);
        pinchk("tx_off", 1'b1, tx_pin);
        $display("test autobaud and disable done");
        finish_test;
    end
endmodule // tb_uart_async_rx_control
